/* File: aal2_rx_cps_classifier.sv */
// aal2 receive cps packet classifier: table lookup, dispatch, counters, event reports
// assumes: upstream hands over each packet with its connection fields; table memory answers reads
`timescale 1ns/1ns
`default_nettype none
module aal2_rx_cps_classifier
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// packet from cell disassembly
	input wire logic pktValid,
	input wire aal2_rx_pkg::pkt_t pkt,
	output logic pktReady,
	// lookup table memory read
	output logic memReq,
	output logic [aal2_rx_pkg::ADDR_W-1:0] memAddr,
	input wire logic memRdValid,
	input wire logic [aal2_rx_pkg::WORD_W-1:0] memRdData,
	// split entry configuration
	input wire logic splitWe,
	input wire logic [aal2_rx_pkg::SEL_W-1:0] splitAddr,
	input wire aal2_rx_pkg::split_t splitData,
	// dispatch to channel processors
	output logic dispValid,
	output aal2_rx_pkg::disp_t disp,
	// connection write back
	output logic wbValid,
	output aal2_rx_pkg::wb_t wb,
	// event report queue
	output logic evValid,
	output aal2_rx_pkg::ev_t ev
);

	typedef enum logic [1:0] {S_IDLE, S_WAIT, S_LOOK} state_t;

	state_t state_reg;
	aal2_rx_pkg::pkt_t pkt_reg;
	logic [aal2_rx_pkg::SEL_W-1:0] sel_reg;
	logic [aal2_rx_pkg::IDX_W-1:0] index;
	logic [aal2_rx_pkg::ENTRY_POS_W-1:0] entryPos;
	logic [aal2_rx_pkg::SEL_W-1:0] selNow;
	logic takeWord;
	aal2_rx_pkg::split_t split;
	aal2_rx_pkg::chan_kind_t kindNow;
	aal2_rx_pkg::coding_t codingNow;

	// ---------------------------------------------------------------
	// index and entry extraction
	// ---------------------------------------------------------------
	assign index = {pkt_reg.uui, pkt_reg.li};
	assign entryPos = index[aal2_rx_pkg::ENTRY_POS_W-1:0];
	assign takeWord = (state_reg == S_WAIT) && memRdValid;

	always_comb
	begin
		selNow = '0;
		for (int i = 0; i < aal2_rx_pkg::ENTRY_PER_WORD; i++)
		begin
			if (int'(entryPos) == i)
			begin
				selNow = memRdData[(aal2_rx_pkg::ENTRY_PER_WORD-1-i)*aal2_rx_pkg::SEL_W +: aal2_rx_pkg::SEL_W];
			end
		end
	end

	split_ram u_split
	(
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.we(splitWe),
		.wrAddr(splitAddr),
		.wrData(splitData),
		.rdEn(takeWord),
		.rdAddr(selNow),
		.rdData(split)
	);

	// ---------------------------------------------------------------
	// decoders
	// ---------------------------------------------------------------
	always_comb
	begin
		unique case (split.chanType)
			aal2_rx_pkg::TYPE_VOICE: kindNow = aal2_rx_pkg::K_VOICE;
			aal2_rx_pkg::TYPE_HDLC: kindNow = aal2_rx_pkg::K_HDLC;
			aal2_rx_pkg::TYPE_CPU: kindNow = aal2_rx_pkg::K_CPU;
			aal2_rx_pkg::TYPE_DELETE: kindNow = aal2_rx_pkg::K_DELETE;
			default: kindNow = aal2_rx_pkg::K_RESERVED;
		endcase
	end

	always_comb
	begin
		unique case (split.voice_coding_info)
			aal2_rx_pkg::VI_PCM: codingNow = aal2_rx_pkg::C_PCM;
			aal2_rx_pkg::VI_ADPCM40: codingNow = aal2_rx_pkg::C_ADPCM40;
			aal2_rx_pkg::VI_ADPCM32: codingNow = aal2_rx_pkg::C_ADPCM32;
			aal2_rx_pkg::VI_ADPCM24: codingNow = aal2_rx_pkg::C_ADPCM24;
			aal2_rx_pkg::VI_ADPCM16: codingNow = aal2_rx_pkg::C_ADPCM16;
			aal2_rx_pkg::VI_SID_INT: codingNow = aal2_rx_pkg::C_SID_INT;
			aal2_rx_pkg::VI_MU_TO_A: codingNow = aal2_rx_pkg::C_MU_TO_A;
			aal2_rx_pkg::VI_A_TO_MU: codingNow = aal2_rx_pkg::C_A_TO_MU;
			aal2_rx_pkg::VI_A_TO_MU_NZ: codingNow = aal2_rx_pkg::C_A_TO_MU_NZ;
			aal2_rx_pkg::VI_MU_TO_MU_NZ: codingNow = aal2_rx_pkg::C_MU_TO_MU_NZ;
			aal2_rx_pkg::VI_SID_EXT: codingNow = aal2_rx_pkg::C_SID_EXT;
			default: codingNow = aal2_rx_pkg::C_RESERVED;
		endcase
	end

	// ---------------------------------------------------------------
	// sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= S_IDLE;
			pktReady <= 1'b0;
			pkt_reg <= '0;
			sel_reg <= '0;
		end
		else if (ce)
		begin
			unique case (state_reg)
				S_IDLE:
				begin
					pktReady <= 1'b1;
					if (pktValid && pktReady)
					begin
						pkt_reg <= pkt;
						pktReady <= 1'b0;
						state_reg <= S_WAIT;
					end
				end
				S_WAIT:
				begin
					if (memRdValid)
					begin
						sel_reg <= selNow;
						state_reg <= S_LOOK;
					end
				end
				S_LOOK:
				begin
					pktReady <= 1'b1;
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// table read request
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			memReq <= 1'b0;
			memAddr <= '0;
		end
		else if (ce)
		begin
			if (state_reg == S_IDLE && pktValid && pktReady)
			begin
				memReq <= 1'b1;
				memAddr <= {pkt.tableBase, pkt.uui, pkt.li[aal2_rx_pkg::LI_W-1:aal2_rx_pkg::ENTRY_POS_W], 1'b0};
			end
			else if (takeWord)
			begin
				memReq <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// dispatch, write back and event report
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dispValid <= 1'b0;
			disp <= '0;
			wbValid <= 1'b0;
			wb <= '0;
			evValid <= 1'b0;
			ev <= '0;
		end
		else if (ce)
		begin
			dispValid <= (state_reg == S_LOOK);
			wbValid <= (state_reg == S_LOOK);
			evValid <= (state_reg == S_LOOK) && (split.report || !pkt_reg.seenBefore);
			if (state_reg == S_LOOK)
			begin
				disp.uui <= pkt_reg.uui;
				disp.li <= pkt_reg.li;
				disp.sel <= sel_reg;
				disp.kind <= kindNow;
				disp.coding <= codingNow;
				disp.chanAddr <= {split.chanPtr, {aal2_rx_pkg::CHAN_SHIFT{1'b0}}};
				wb.connBase <= pkt_reg.connBase;
				wb.pktCount <= pkt_reg.pktCount + aal2_rx_pkg::PKTCNT_W'(1);
				wb.octetCount <= pkt_reg.octetCount + aal2_rx_pkg::OCTCNT_W'(pkt_reg.li)
					+ aal2_rx_pkg::OCTCNT_W'(1);
				wb.seenBefore <= 1'b1;
				ev.init <= !pkt_reg.seenBefore;
				ev.report <= split.report;
				ev.connBase <= pkt_reg.connBase;
				ev.uui <= pkt_reg.uui;
				ev.li <= pkt_reg.li;
				ev.timestamp <= pkt_reg.timestamp;
			end
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_addr;
		@(posedge clock) disable iff (!rst_n)
		(memReq && state_reg == S_WAIT) |-> memAddr == {pkt_reg.tableBase, index[aal2_rx_pkg::IDX_W-1:2], 1'b0};
	endproperty
	a_addr: assert property (p_addr) else $error("table address wrong");

	property p_index;
		@(posedge clock) disable iff (!rst_n)
		dispValid |-> {disp.uui, disp.li} == {ev.uui, ev.li} && wb.connBase == ev.connBase;
	endproperty
	a_index: assert property (p_index) else $error("index fields disagree");

	property p_top_nibble;
		@(posedge clock) disable iff (!rst_n)
		(ce && takeWord && entryPos == 2'h0) |=> sel_reg == 4'($past(memRdData) >> 12);
	endproperty
	a_top_nibble: assert property (p_top_nibble) else $error("entry 0 not in top nibble");

	property p_low_nibble;
		@(posedge clock) disable iff (!rst_n)
		(ce && takeWord && entryPos == 2'h3) |=> sel_reg == 4'($past(memRdData));
	endproperty
	a_low_nibble: assert property (p_low_nibble) else $error("entry 3 not in low nibble");

	property p_pktcnt;
		@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_LOOK) |=> wbValid && wb.pktCount == pkt_reg.pktCount + 16'h1;
	endproperty
	a_pktcnt: assert property (p_pktcnt) else $error("packet count not incremented");

	property p_octet;
		@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_LOOK) |=> wb.octetCount == pkt_reg.octetCount + {26'h0, pkt_reg.li} + 32'h1;
	endproperty
	a_octet: assert property (p_octet) else $error("octet count wrong");

	property p_event;
		@(posedge clock) disable iff (!rst_n)
		dispValid |-> evValid == (ev.report || ev.init);
	endproperty
	a_event: assert property (p_event) else $error("event without cause");

	property p_init;
		@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_LOOK && !pkt_reg.seenBefore) |=> evValid && ev.init;
	endproperty
	a_init: assert property (p_init) else $error("first packet without init event");

	property p_chan;
		@(posedge clock) disable iff (!rst_n)
		dispValid |-> disp.chanAddr[4:0] == 5'h0;
	endproperty
	a_chan: assert property (p_chan) else $error("channel address not 32-byte aligned");

	property p_wrap;
		@(posedge clock) disable iff (!rst_n)
		(ce && state_reg == S_LOOK && pkt_reg.pktCount == 16'hffff) |=> wb.pktCount == 16'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("packet count does not wrap");

	property p_pulse;
		@(posedge clock) disable iff (!rst_n)
		(ce && dispValid) |=> !dispValid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("dispatch longer than one cycle");

	c_first: cover property (@(posedge clock) disable iff (!rst_n) evValid && ev.init);
	c_report: cover property (@(posedge clock) disable iff (!rst_n) evValid && ev.report && !ev.init);
	c_quiet: cover property (@(posedge clock) disable iff (!rst_n) dispValid && !evValid);
	c_delete: cover property (@(posedge clock) disable iff (!rst_n) dispValid && disp.kind == aal2_rx_pkg::K_DELETE);

endmodule
`default_nettype wire

/* File: aal2_rx_cps_classifier_bench.sv */
// testbench: split config, packets through lookup, dispatch, counters, events
// assumes: table memory model beside the classifier, one clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module aal2_rx_cps_classifier_bench;
	logic clock = 0;
	logic rst_n = 0;
	logic ce = 1;
	logic pktValid = 0;
	logic splitWe = 0;
	logic [3:0] splitAddr = 4'h0;
	logic [3:0] lag = 4'h0;
	aal2_rx_pkg::pkt_t pkt = '0;
	aal2_rx_pkg::split_t splitData = '0;
	aal2_rx_pkg::split_t splits [16];
	logic pktReady, memReq, memRdValid, dispValid, wbValid, evValid;
	logic [aal2_rx_pkg::ADDR_W-1:0] memAddr;
	logic [aal2_rx_pkg::WORD_W-1:0] memRdData;
	aal2_rx_pkg::disp_t disp;
	aal2_rx_pkg::wb_t wb;
	aal2_rx_pkg::ev_t ev;
	int mismatches = 0;
	int nCompared = 0;

	always #20 clock = ~clock;

	aal2_rx_cps_classifier dut (.clock(clock), .rst_n(rst_n), .ce(ce), .pktValid(pktValid), .pkt(pkt),
		.pktReady(pktReady), .memReq(memReq), .memAddr(memAddr), .memRdValid(memRdValid),
		.memRdData(memRdData), .splitWe(splitWe), .splitAddr(splitAddr), .splitData(splitData),
		.dispValid(dispValid), .disp(disp), .wbValid(wbValid), .wb(wb), .evValid(evValid), .ev(ev));
	aal2_tbl_mem_model mem (.clock(clock), .rst_n(rst_n), .ce(ce), .memReq(memReq), .memAddr(memAddr),
		.memRdValid(memRdValid), .memRdData(memRdData), .lag(lag));

	// ---------------------------------------------------------------
	// expected decodes
	// ---------------------------------------------------------------
	function automatic aal2_rx_pkg::chan_kind_t kindOf(input logic [2:0] t);
		case (t)
			3'h0: return aal2_rx_pkg::K_VOICE;
			3'h1: return aal2_rx_pkg::K_HDLC;
			3'h2: return aal2_rx_pkg::K_CPU;
			3'h7: return aal2_rx_pkg::K_DELETE;
			default: return aal2_rx_pkg::K_RESERVED;
		endcase
	endfunction

	function automatic aal2_rx_pkg::coding_t codingOf(input logic [3:0] v);
		if (v <= 4'h5)
			return aal2_rx_pkg::coding_t'(v);
		if (v >= 4'h8 && v <= 4'hc)
			return aal2_rx_pkg::coding_t'(v - 4'h2);
		return aal2_rx_pkg::C_RESERVED;
	endfunction

	// ---------------------------------------------------------------
	// closing
	// ---------------------------------------------------------------
	task automatic complete_run();
		$display("compared %0d mismatches %0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// one packet through the block
	// ---------------------------------------------------------------
	task automatic sendPkt(input int k);
		aal2_rx_pkg::pkt_t p;
		aal2_rx_pkg::split_t sp;
		logic [23:0] a;
		logic [15:0] w;
		logic [3:0] s;
		logic evExp;
		int n;
		p.uui = (k == 1) ? 5'h1f : 5'(k * 7);
		p.li = (k == 1) ? 6'h3f : 6'(k * 13);
		p.tableBase = {12'h2a5, 2'(k >> 2)};
		p.pktCount = 16'hffff - 16'(k);
		p.octetCount = 32'hffff_ffc0 + 32'(k);
		p.seenBefore = k[1];
		p.connBase = 24'(k * 24'h012345);
		p.timestamp = 32'(k) * 32'h01010101;
		n = 0;
		while (pktReady !== 1'b1 && n < 40)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		`CHK("pktReady", 1'b1, pktReady)
		lag = 4'(k % 8);
		pkt = p;
		pktValid = 1;
		@(posedge clock);
		#1;
		pktValid = 0;
		pkt = ~p;
		a = {p.tableBase, p.uui, p.li[5:2], 1'b0};
		`CHK("memReq", 1'b1, memReq)
		`CHK("memAddr", a, memAddr)
		`CHK("pktReady busy", 1'b0, pktReady)
		if (k == 5)
		begin
			ce = 0;
			repeat (3)
			begin
				@(posedge clock);
				#1;
			end
			`CHK("memReq frozen", 1'b1, memReq)
			`CHK("memAddr frozen", a, memAddr)
			`CHK("dispValid frozen", 1'b0, dispValid)
			ce = 1;
		end
		w = a[16:1] ^ 16'h9c5a;
		s = 4'(w >> (4 * (3 - p.li[1:0])));
		sp = splits[s];
		evExp = sp.report | ~p.seenBefore;
		n = 0;
		while (dispValid !== 1'b1 && n < 30)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		`CHK("dispValid", 1'b1, dispValid)
		`CHK("disp.uui", p.uui, disp.uui)
		`CHK("disp.li", p.li, disp.li)
		`CHK("disp.sel", s, disp.sel)
		`CHK("disp.kind", kindOf(sp.chanType), disp.kind)
		`CHK("disp.coding", codingOf(sp.voice_coding_info), disp.coding)
		`CHK("disp.chanAddr", {sp.chanPtr, 5'h0}, disp.chanAddr)
		`CHK("wbValid", 1'b1, wbValid)
		`CHK("wb.connBase", p.connBase, wb.connBase)
		`CHK("wb.pktCount", p.pktCount + 16'h1, wb.pktCount)
		`CHK("wb.octetCount", p.octetCount + 32'(p.li) + 32'h1, wb.octetCount)
		`CHK("wb.seenBefore", 1'b1, wb.seenBefore)
		`CHK("evValid", evExp, evValid)
		if (evExp)
		begin
			`CHK("ev.init", ~p.seenBefore, ev.init)
			`CHK("ev.report", sp.report, ev.report)
			`CHK("ev.connBase", p.connBase, ev.connBase)
			`CHK("ev.uuiLi", {p.uui, p.li}, {ev.uui, ev.li})
			`CHK("ev.timestamp", p.timestamp, ev.timestamp)
		end
		`CHK("pktReady again", 1'b1, pktReady)
		if (k == 9)
		begin
			ce = 0;
			@(posedge clock);
			#1;
			`CHK("dispValid held", 1'b1, dispValid)
			`CHK("wbValid held", 1'b1, wbValid)
			ce = 1;
			@(posedge clock);
			#1;
			`CHK("dispValid ends", 1'b0, dispValid)
		end
	endtask

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clock);
		#1;
		rst_n = 1;
		@(posedge clock);
		#1;
		for (int i = 0; i < 16; i++)
		begin
			splits[i].report = i[0] ^ i[2];
			splits[i].chanType = 3'(i);
			splits[i].voice_coding_info = 4'(i);
			splits[i].chanPtr = 19'(i * 32'h1357b);
			splitWe = 1;
			splitAddr = 4'(i);
			splitData = splits[i];
			@(posedge clock);
			#1;
		end
		splitWe = 0;
		for (int k = 0; k < 64; k++)
			sendPkt(k);
		rst_n = 0;
		#5;
		`CHK("pktReady in reset", 1'b0, pktReady)
		`CHK("memReq in reset", 1'b0, memReq)
		`CHK("evValid in reset", 1'b0, evValid)
		@(posedge clock);
		#1;
		rst_n = 1;
		@(posedge clock);
		#1;
		`CHK("pktReady after reset", 1'b1, pktReady)
		sendPkt(64);
		complete_run();
	end

	initial
	begin
		#200000;
		mismatches++;
		complete_run();
	end
endmodule
`default_nettype wire

/* File: aal2_rx_pkg.sv */
// package: constants, codes and carrier types for the aal2 receive classifier
// assumes: every user writes aal2_rx_pkg::name, nothing is imported
package aal2_rx_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int UUI_W = 5;
	localparam int LI_W = 6;
	localparam int IDX_W = UUI_W + LI_W;
	localparam int TBL_ENTRIES = 2048;
	localparam int SEL_W = 4;
	localparam int NUM_CHAN = 16;
	localparam int ENTRY_PER_WORD = 4;
	localparam int ENTRY_POS_W = 2;
	localparam int WORD_W = ENTRY_PER_WORD * SEL_W;
	localparam int ADDR_W = 24;
	localparam int TBL_SHIFT = 10;
	localparam int TBASE_W = ADDR_W - TBL_SHIFT;
	localparam int CHAN_SHIFT = 5;
	localparam int CHAN_PTR_W = ADDR_W - CHAN_SHIFT;
	localparam int PKTCNT_W = 16;
	localparam int OCTCNT_W = 32;
	localparam int TS_W = 32;
	localparam int TYPE_W = 3;
	localparam int VINFO_W = 4;

	// ---------------------------------------------------------------
	// channel type and voice coding codes
	// ---------------------------------------------------------------
	localparam logic [TYPE_W-1:0] TYPE_VOICE = 3'h0;
	localparam logic [TYPE_W-1:0] TYPE_HDLC = 3'h1;
	localparam logic [TYPE_W-1:0] TYPE_CPU = 3'h2;
	localparam logic [TYPE_W-1:0] TYPE_DELETE = 3'h7;
	localparam logic [VINFO_W-1:0] VI_PCM = 4'h0;
	localparam logic [VINFO_W-1:0] VI_ADPCM40 = 4'h1;
	localparam logic [VINFO_W-1:0] VI_ADPCM32 = 4'h2;
	localparam logic [VINFO_W-1:0] VI_ADPCM24 = 4'h3;
	localparam logic [VINFO_W-1:0] VI_ADPCM16 = 4'h4;
	localparam logic [VINFO_W-1:0] VI_SID_INT = 4'h5;
	localparam logic [VINFO_W-1:0] VI_MU_TO_A = 4'h8;
	localparam logic [VINFO_W-1:0] VI_A_TO_MU = 4'h9;
	localparam logic [VINFO_W-1:0] VI_A_TO_MU_NZ = 4'ha;
	localparam logic [VINFO_W-1:0] VI_MU_TO_MU_NZ = 4'hb;
	localparam logic [VINFO_W-1:0] VI_SID_EXT = 4'hc;

	typedef enum logic [2:0] {K_VOICE, K_HDLC, K_CPU, K_DELETE, K_RESERVED} chan_kind_t;
	typedef enum logic [3:0] {C_PCM, C_ADPCM40, C_ADPCM32, C_ADPCM24, C_ADPCM16, C_SID_INT,
		C_MU_TO_A, C_A_TO_MU, C_A_TO_MU_NZ, C_MU_TO_MU_NZ, C_SID_EXT, C_RESERVED} coding_t;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [UUI_W-1:0] uui;
		logic [LI_W-1:0] li;
		logic [TBASE_W-1:0] tableBase;
		logic [PKTCNT_W-1:0] pktCount;
		logic [OCTCNT_W-1:0] octetCount;
		logic seenBefore;
		logic [ADDR_W-1:0] connBase;
		logic [TS_W-1:0] timestamp;
	} pkt_t;

	typedef struct packed {
		logic report;
		logic [TYPE_W-1:0] chanType;
		logic [VINFO_W-1:0] voice_coding_info;
		logic [CHAN_PTR_W-1:0] chanPtr;
	} split_t;

	typedef struct packed {
		logic [UUI_W-1:0] uui;
		logic [LI_W-1:0] li;
		logic [SEL_W-1:0] sel;
		chan_kind_t kind;
		coding_t coding;
		logic [ADDR_W-1:0] chanAddr;
	} disp_t;

	typedef struct packed {
		logic [ADDR_W-1:0] connBase;
		logic [PKTCNT_W-1:0] pktCount;
		logic [OCTCNT_W-1:0] octetCount;
		logic seenBefore;
	} wb_t;

	typedef struct packed {
		logic init;
		logic report;
		logic [ADDR_W-1:0] connBase;
		logic [UUI_W-1:0] uui;
		logic [LI_W-1:0] li;
		logic [TS_W-1:0] timestamp;
	} ev_t;

endpackage

/* File: aal2_tbl_mem_model.sv */
// lookup table memory model: answers word reads after a chosen lag
// assumes: one clock, requester holds memReq and memAddr until answered
`timescale 1ns/1ns
`default_nettype none
module aal2_tbl_mem_model
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// table read
	input wire logic memReq,
	input wire logic [aal2_rx_pkg::ADDR_W-1:0] memAddr,
	output logic memRdValid,
	output logic [aal2_rx_pkg::WORD_W-1:0] memRdData,
	// answer delay in cycles
	input wire logic [3:0] lag
);
	logic done;
	logic [3:0] cnt;

	// ---------------------------------------------------------------
	// answer once per request, data toggles when not valid and ce is high
	// ---------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			memRdValid <= 1'b0;
			done <= 1'b0;
			cnt <= 4'h0;
			memRdData <= 16'h0;
		end
		else if (!ce)
		begin
			done <= done;
		end
		else if (memRdValid)
		begin
			memRdValid <= 1'b0;
			done <= 1'b1;
			memRdData <= ~memRdData;
		end
		else if (!memReq)
		begin
			done <= 1'b0;
			cnt <= 4'h0;
			memRdData <= ~memRdData;
		end
		else if (!done && cnt == lag)
		begin
			memRdValid <= 1'b1;
			memRdData <= memAddr[16:1] ^ 16'h9c5a;
		end
		else
		begin
			cnt <= done ? cnt : cnt + 4'h1;
			memRdData <= ~memRdData;
		end
	end
endmodule
`default_nettype wire

/* File: split_ram.sv */
// holds the sixteen channel split entries, registered read
// assumes: one clock, written by configuration logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module split_ram
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// write port
	input wire logic we,
	input wire logic [aal2_rx_pkg::SEL_W-1:0] wrAddr,
	input wire aal2_rx_pkg::split_t wrData,
	// read port
	input wire logic rdEn,
	input wire logic [aal2_rx_pkg::SEL_W-1:0] rdAddr,
	output aal2_rx_pkg::split_t rdData
);

	aal2_rx_pkg::split_t mem [aal2_rx_pkg::NUM_CHAN];

	always_ff @(posedge clock)
	begin
		if (ce && we)
		begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdData <= '0;
		end
		else if (ce && rdEn)
		begin
			rdData <= mem[rdAddr];
		end
	end

endmodule
`default_nettype wire
